//--- rtl/pn_recovery_pkg.sv
package pn_recovery_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses on APB)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL1  = 8'h00;
  localparam logic [7:0] ADDR_CTRL2  = 8'h04;
  localparam logic [7:0] ADDR_QUANTA = 8'h08;
  localparam logic [7:0] ADDR_SPP    = 8'h0C;
  localparam logic [7:0] ADDR_UPPER  = 8'h10;
  localparam logic [7:0] ADDR_LOWER  = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_MASK   = 8'h1C;
  localparam logic [7:0] ADDR_STATE  = 8'h20;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL1_EN_BIT    = 0;
  localparam int CTRL1_FD_EN_BIT = 1;
  localparam int CTRL1_FILT_LSB  = 2;
  localparam int CTRL1_RXSEL_BIT = 4;
  localparam int ST_WAKE         = 0;
  localparam int ST_INACTIVE     = 1;
  localparam int ST_LIMIT        = 2;
  localparam int STATE_INACT_BIT = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] QUANTA_RESET = 8'h28;
  localparam logic [5:0] SPP_RESET    = 6'h33;
  localparam logic [7:0] UPPER_RESET  = 8'h30;
  localparam logic [7:0] LOWER_RESET  = 8'h20;
  localparam logic [1:0] CLKSEL_RESET = 2'h0;
  localparam logic [2:0] MASK_RESET   = 3'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned SILENCE_MIN_MS = 600;
  localparam int unsigned SILENCE_MAX_MS = 1200;
  localparam int unsigned SILENCE_DEFAULT_CYCLES =
    SILENCE_MIN_MS * (CLK_HZ / 1000);
  localparam int unsigned WAKE_MAX_US    = 100;
  localparam int unsigned WAKE_CYCLES    = WAKE_MAX_US * (CLK_HZ / 1_000_000);
  localparam int unsigned BIT_MIN_US     = 1;
  localparam logic [7:0]  BIT_MIN_CYCLES =
    8'(BIT_MIN_US * (CLK_HZ / 1_000_000));
  localparam int unsigned ARB_MAX_KBPS   = 500;
  localparam logic [7:0]  ARB_MIN_CYCLES = 8'(CLK_HZ / (ARB_MAX_KBPS * 1000));
  // Filter thresholds in 64ths of the arbitration bit
  localparam logic [3:0]  FD4_MUL  = 4'hB;
  localparam logic [3:0]  FD10_MUL = 4'h5;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FILT_OFF  = 2'b00,
    FILT_2M   = 2'b01,
    FILT_5M   = 2'b10,
    FILT_RSVD = 2'b11
  } fd_pulse_filter_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic        en;
    logic        fd_en;
    fd_pulse_filter_t  fd_filt;
    logic        rx_sel;
    logic [1:0]  clk_sel;
    logic [7:0]  quanta;
    logic [5:0]  spp;
    logic [7:0]  upper;
    logic [7:0]  lower;
    logic [2:0]  status;
    logic [2:0]  mask;
    logic        irq_n;
    logic [7:0]  len;
    logic [7:0]  phase;
    logic        rx_prev;
    logic        samp;
    logic        bit_val;
    logic [23:0] silence;
    logic        inactive;
    logic        fd_active;
    logic [7:0]  dom_cnt;
    logic        filt_rx;
    logic        woken;
    logic        supply;
  } state_t;

endpackage

//--- rtl/input_sync.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// Three-stage input synchroniser with agreement check
// ------------------------------------------------------------------
module input_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Pin side
  input  wire logic pin_in,
  // Clocked side
  output logic      level
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync_t;

  sync_t s;
  sync_t next_s;

  // Output follows only once stages two and three agree
  always_comb begin
    next_s = s;
    next_s.s1 = pin_in;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    if (s.s2 == s.s3) begin
      next_s.lvl = s.s3;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= {4{RESET_VAL}};
    end else begin
      s <= next_s;
    end
  end

  assign level = s.lvl;

endmodule // input_sync

`default_nettype wire

//--- rtl/partial_net_clock_recovery.sv
`timescale 1ns/10ps
`default_nettype none

module partial_net_clock_recovery
  import pn_recovery_pkg::*;
#(
  parameter int unsigned SILENCE_CYCLES = pn_recovery_pkg::SILENCE_DEFAULT_CYCLES
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Bus receiver pin
  input  wire logic        bus_rx,
  // Frame decoder events
  input  wire logic        fdf_detected,
  input  wire logic        eof_detected,
  input  wire logic        wake_pattern_end,
  input  wire logic        wake_frame_end,
  // Device mode
  input  wire logic        mode_stop,
  input  wire logic        mode_sleep,
  // Decoder timing
  output logic             sample_strobe,
  output logic             sampled_bit,
  output logic [7:0]       bit_length,
  output logic [1:0]       recovery_input_clock_select,
  // Status
  output logic             bus_inactive,
  output logic             interrupt_out_n,
  output logic             main_supply_output
);

  import pn_recovery_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  state_t      s;
  state_t      next_s;
  logic        rx;
  logic        wr_en;
  logic        rd_acc;
  logic        mapped;
  logic [31:0] rd_word;
  logic [7:0]  eff_q;
  logic        fall;
  logic        activity;
  logic [7:0]  nl;
  logic        lim;
  logic [13:0] sp_prod;
  logic [7:0]  sp_cyc;
  logic [11:0] thr_prod;
  logic [7:0]  thr;
  logic        wake_ev;
  logic        fd_allowed;
  logic [2:0]  events;

  // ----------------------------------------------------------------
  // Bus pin synchroniser
  // ----------------------------------------------------------------
  input_sync #(
    .RESET_VAL (1'b1)
  ) u_rx_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (bus_rx),
    .level   (rx)
  );

  // ----------------------------------------------------------------
  // Decode and helper terms
  // ----------------------------------------------------------------
  assign wr_en   = psel & penable & pwrite;
  assign rd_acc  = psel & penable & ~pwrite;
  assign fall    = s.rx_prev & ~rx;
  assign activity = s.rx_prev ^ rx;
  assign wake_ev = wake_pattern_end | wake_frame_end;
  // Programmed quanta, never shorter than the minimum bit time
  assign eff_q   = (s.quanta < BIT_MIN_CYCLES) ? BIT_MIN_CYCLES
                                               : s.quanta;
  // Sampling point as a fraction in 64ths of the bit
  assign sp_prod = s.len * s.spp;
  assign sp_cyc  = sp_prod[13:6];
  // Dominant acceptance threshold from the filter field
  assign thr_prod = s.len * ((s.fd_filt == FILT_5M) ? FD10_MUL
                                                    : FD4_MUL);
  assign thr = {2'h0, thr_prod[11:6]};
  assign fd_allowed = s.fd_en & s.rx_sel & (s.len >= ARB_MIN_CYCLES)
                    & ((s.fd_filt == FILT_2M)
                    | (s.fd_filt == FILT_5M));

  // Next bit length after an edge measurement
  // An edge seen on the last phase is on time; phase 0 is one cycle late
  always_comb begin
    nl = s.len;
    if (s.phase == s.len - 8'h01) begin
      nl = s.len;
    end else if (s.phase > (s.len >> 1)) begin
      nl = s.len - 8'h01;
    end else begin
      nl = s.len + 8'h01;
    end
  end
  assign lim = (nl >= s.upper) | (nl <= s.lower) | (nl < BIT_MIN_CYCLES);

  // Register read mux
  always_comb begin
    mapped  = 1'b1;
    rd_word = 32'h0;
    unique case (paddr[7:0])
      ADDR_CTRL1:  rd_word = {27'h0, s.rx_sel, s.fd_filt, s.fd_en, s.en};
      ADDR_CTRL2:  rd_word = {30'h0, s.clk_sel};
      ADDR_QUANTA: rd_word = {24'h0, s.quanta};
      ADDR_SPP:    rd_word = {26'h0, s.spp};
      ADDR_UPPER:  rd_word = {24'h0, s.upper};
      ADDR_LOWER:  rd_word = {24'h0, s.lower};
      ADDR_STATUS: rd_word = {29'h0, s.status};
      ADDR_MASK:   rd_word = {29'h0, s.mask};
      ADDR_STATE:  rd_word = {23'h0, s.inactive, s.len};
      default:     mapped  = 1'b0;
    endcase
    if (paddr[31:8] != 24'h0) begin
      mapped  = 1'b0;
      rd_word = 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    events = 3'h0;
    // Read data latched in the setup cycle
    if (psel & ~penable) begin
      next_s.rdata = rd_word;
    end
    // Register writes
    if (wr_en & mapped) begin
      unique case (paddr[7:0])
        ADDR_CTRL1: begin
          next_s.en      = pwdata[CTRL1_EN_BIT];
          next_s.fd_en   = pwdata[CTRL1_FD_EN_BIT];
          next_s.fd_filt = fd_pulse_filter_t'(pwdata[CTRL1_FILT_LSB +: 2]);
          next_s.rx_sel  = pwdata[CTRL1_RXSEL_BIT];
        end
        ADDR_CTRL2:  next_s.clk_sel = pwdata[1:0];
        ADDR_QUANTA: next_s.quanta  = pwdata[7:0];
        ADDR_SPP:    next_s.spp     = pwdata[5:0];
        ADDR_UPPER:  next_s.upper   = pwdata[7:0];
        ADDR_LOWER:  next_s.lower   = pwdata[7:0];
        ADDR_MASK:   next_s.mask    = pwdata[2:0];
        default: begin
        end
      endcase
    end
    // Bit clock: phase counter and edge tracking
    next_s.rx_prev = rx;
    next_s.samp    = 1'b0;
    if (s.phase >= s.len - 8'h01) begin
      next_s.phase = 8'h00;
    end else begin
      next_s.phase = s.phase + 8'h01;
    end
    if (!s.en) begin
      next_s.len = eff_q;
    end else if (fall) begin
      next_s.phase = 8'h00;
      if (lim) begin
        next_s.len = eff_q;
        events[ST_LIMIT] = 1'b1;
      end else begin
        next_s.len = nl;
      end
    end
    if (s.phase == sp_cyc) begin
      next_s.samp    = 1'b1;
      next_s.bit_val = s.filt_rx;
    end
    // Silence timeout
    if (activity) begin
      next_s.silence  = 24'h0;
      next_s.inactive = 1'b0;
    end else if (s.silence == 24'(SILENCE_CYCLES - 1)) begin
      if (!s.inactive) begin
        events[ST_INACTIVE] = 1'b1;
      end
      next_s.inactive = 1'b1;
    end else begin
      next_s.silence = s.silence + 24'h1;
    end
    // FD tolerant pulse filter between FDF and EOF
    if (eof_detected) begin
      next_s.fd_active = 1'b0;
    end else if (fdf_detected & fd_allowed) begin
      next_s.fd_active = 1'b1;
    end
    if (s.fd_active) begin
      if (!rx) begin
        if (s.dom_cnt != 8'hFF) begin
          next_s.dom_cnt = s.dom_cnt + 8'h01;
        end
        if (s.dom_cnt >= thr) begin
          next_s.filt_rx = 1'b0;
        end
      end else begin
        next_s.dom_cnt = 8'h00;
        next_s.filt_rx = 1'b1;
      end
    end else begin
      next_s.dom_cnt = 8'h00;
      next_s.filt_rx = rx;
    end
    // Wake reaction
    events[ST_WAKE] = wake_ev;
    if (!mode_sleep) begin
      next_s.woken = 1'b0;
    end else if (wake_ev) begin
      next_s.woken = 1'b1;
    end
    next_s.supply = ~mode_sleep | next_s.woken;
    // Status: read clears only the bits it returned, a new event wins
    if (rd_acc & (paddr == {24'h0, ADDR_STATUS})) begin
      next_s.status = s.status & ~s.rdata[2:0];
    end
    next_s.status = next_s.status | events;
    next_s.irq_n  = ~|(next_s.status & next_s.mask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s         <= '0;
      s.fd_filt <= FILT_OFF;
      s.clk_sel <= CLKSEL_RESET;
      s.quanta  <= QUANTA_RESET;
      s.spp     <= SPP_RESET;
      s.upper   <= UPPER_RESET;
      s.lower   <= LOWER_RESET;
      s.mask    <= MASK_RESET;
      s.irq_n   <= 1'b1;
      s.len     <= QUANTA_RESET;
      s.rx_prev <= 1'b1;
      s.bit_val <= 1'b1;
      s.filt_rx <= 1'b1;
      s.supply  <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~mapped;
  assign prdata   = s.rdata;
  assign sample_strobe = s.samp;
  assign sampled_bit   = s.bit_val;
  assign bit_length    = s.len;
  assign recovery_input_clock_select = s.clk_sel;
  assign bus_inactive       = s.inactive;
  assign interrupt_out_n    = s.irq_n;
  assign main_supply_output = s.supply;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence short_edge_s;
    s.en && fall && (s.phase > (s.len >> 1))
      && (s.phase != s.len - 8'h01) && !lim;
  endsequence

  sequence limit_edge_s;
    s.en && fall && lim;
  endsequence

  edge_adjust_a: assert property (short_edge_s |=>
    s.len == $past(s.len) - 8'h01)
    else $error("bit length not shortened after early edge");

  limit_reload_a: assert property (limit_edge_s |=>
    (s.len == $past(eff_q)) && s.status[ST_LIMIT])
    else $error("limit did not reload programmed quanta");

  fixed_length_a: assert property (!s.en |=>
    s.len == $past(eff_q))
    else $error("bit length changed while recovery is off");

  sample_point_a: assert property (!(wr_en && paddr[7:0] == ADDR_SPP)
    |=> s.spp == $past(s.spp))
    else $error("sampling point changed without a write");

  silence_flag_a: assert property (
    (s.silence == 24'(SILENCE_CYCLES - 1)) && !activity && !s.inactive
    |=> s.inactive && s.status[ST_INACTIVE])
    else $error("bus not declared inactive after silence");

  wake_react_a: assert property (wake_ev && s.mask[ST_WAKE]
    |-> ##[1:2] !interrupt_out_n)
    else $error("wake not signalled in time");

  supply_wake_a: assert property (wake_ev && mode_sleep
    |=> main_supply_output [*2])
    else $error("main supply not raised on wake from sleep");

  min_bit_a: assert property (s.len >= BIT_MIN_CYCLES)
    else $error("bit length below minimum bit time");

  fd_pulse_filter_a: assert property ($fell(s.filt_rx) && $past(s.fd_active)
    |-> $past(s.dom_cnt) >= $past(thr))
    else $error("short dominant pulse passed the filter");

  fd_gate_a: assert property ($rose(s.fd_active)
    |-> $past(fd_allowed) && $past(fdf_detected))
    else $error("Fd_pulse_filter started outside its conditions");

endmodule // partial_net_clock_recovery

`default_nettype wire

//--- testbench/can_node_model.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Bus node driving the receiver pin, recessive while idle
// ----------------------------------------------------------------
module can_node_model (
  // Clock
  input  wire logic pclk,
  // Bus level at the receiver
  output var logic  bus_rx
);
  // Idle bus is recessive, the level the bus bias pulls it to
  initial bus_rx = 1'b1;

  // Falling edge every period cycles, dominant for low_len cycles
  task automatic send(input int period, input int low_len, input int count);
    for (int i = 0; i < count; i++) begin
      @(posedge pclk) bus_rx <= 1'b0;
      repeat (low_len) @(posedge pclk);
      bus_rx <= 1'b1;
      repeat (period - low_len - 1) @(posedge pclk);
    end
  endtask
endmodule // can_node_model

`default_nettype wire

//--- testbench/partial_net_clock_recovery_tb.sv
`timescale 1ns/10ps
`default_nettype none

module partial_net_clock_recovery_tb
  import pn_recovery_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, q;
  logic        bus_rx, fdf_detected, eof_detected, wake_pattern_end;
  logic        wake_frame_end, mode_stop, mode_sleep, sample_strobe;
  logic        sampled_bit, bus_inactive, interrupt_out_n;
  logic        main_supply_output, apb_err;
  logic [7:0]  bit_length;
  logic [1:0]  clk_sel;
  int          num_errors, total_checks, cycles, zeros, n;
  logic [7:0]  fd_ctrl [5] = '{8'h16, 8'h16, 8'h1A, 8'h1A, 8'h06};
  int          fd_low  [5] = '{5, 8, 3, 5, 5};
  logic [31:0] fd_exp  [5] = '{0, 1, 0, 1, 1};
  logic [7:0]  rst_addr [6] = '{ADDR_QUANTA, ADDR_SPP, ADDR_UPPER,
                                ADDR_LOWER, ADDR_MASK, ADDR_CTRL1};
  logic [31:0] rst_val  [6] = '{32'h28, 32'h33, 32'h30, 32'h20, 0, 0};

  partial_net_clock_recovery #(.SILENCE_CYCLES(50)) partial_net_clock_recovery_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .bus_rx(bus_rx),
    .fdf_detected(fdf_detected), .eof_detected(eof_detected),
    .wake_pattern_end(wake_pattern_end), .wake_frame_end(wake_frame_end),
    .mode_stop(mode_stop), .mode_sleep(mode_sleep),
    .sample_strobe(sample_strobe), .sampled_bit(sampled_bit),
    .bit_length(bit_length), .recovery_input_clock_select(clk_sel),
    .bus_inactive(bus_inactive), .interrupt_out_n(interrupt_out_n),
    .main_supply_output(main_supply_output));

  can_node_model can_node_model_inst (.pclk(pclk), .bus_rx(bus_rx));

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // APB master: setup, then access held until pready
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h000000, a};
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    // Access lasts until pready is seen high; the hang guard ends a stall
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    apb_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One-cycle decoder event pulse
  task automatic pulse(input int which);
    @(posedge pclk);
    {eof_detected, fdf_detected, wake_frame_end, wake_pattern_end}
      <= 4'(1 << which);
    @(posedge pclk) {eof_detected, fdf_detected, wake_frame_end,
                     wake_pattern_end} <= 4'h0;
  endtask

  // Clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      print_verdict;
    end
  end

  // Strobes that sampled a dominant level
  always @(posedge pclk) if (sample_strobe === 1'b1 && sampled_bit === 1'b0) zeros++;

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, fdf_detected, eof_detected} = 6'h00;
    {wake_pattern_end, wake_frame_end, mode_stop} = 3'h0;
    mode_sleep = 1'b1;
    paddr = 32'h0;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    @(negedge pclk) presetn = 1'b1;
    repeat (6) @(posedge pclk);
    chk("supply in sleep", main_supply_output, 0);
    chk("bit length", bit_length, 8'h28);
    for (int i = 0; i < 6; i++) begin
      apb(0, rst_addr[i], 0);
      chk("reset value", q, rst_val[i]);
    end
    apb(0, 8'h24, 0);
    chk("unmapped err", apb_err, 1);
    chk("unmapped data", q, 0);
    // Wake frame from sleep raises the main supply
    pulse(1);
    n = 0;
    while (main_supply_output !== 1'b1 && n < WAKE_CYCLES) begin
      @(posedge pclk);
      n++;
    end
    chk("wake supply", main_supply_output, 1);
    mode_sleep <= 1'b0;
    apb(1, ADDR_MASK, 1);
    apb(0, ADDR_STATUS, 0);
    pulse(0);
    n = 0;
    while (interrupt_out_n !== 1'b0 && n < WAKE_CYCLES) begin
      @(posedge pclk);
      n++;
    end
    chk("wake irq", interrupt_out_n, 0);
    apb(0, ADDR_STATUS, 0);
    chk("wake status", q & 1, 1);
    @(posedge pclk);
    chk("irq cleared", interrupt_out_n, 1);
    // Recovery off: quanta used unchanged, clamped at 1 us
    apb(1, ADDR_QUANTA, 8'h2C);
    can_node_model_inst.send(30, 4, 6);
    chk("fixed length", bit_length, 8'h2C);
    apb(1, ADDR_QUANTA, 8'h10);
    repeat (3) @(posedge pclk);
    chk("min length", bit_length, 8'h14);
    apb(1, ADDR_QUANTA, 8'h28);
    // Silence timeout
    can_node_model_inst.send(40, 3, 1);
    repeat (10) @(posedge pclk);
    chk("still active", bus_inactive, 0);
    repeat (20) @(posedge pclk);
    chk("inactive", bus_inactive, 1);
    apb(0, ADDR_STATUS, 0);
    chk("inactive status", q & 2, 2);
    can_node_model_inst.send(40, 3, 1);
    repeat (8) @(posedge pclk);
    chk("active again", bus_inactive, 0);
    // Recovery tracks a faster bus
    apb(1, ADDR_CTRL2, 2);
    @(posedge pclk);
    chk("clock select", clk_sel, 2);
    apb(1, ADDR_CTRL1, 1);
    can_node_model_inst.send(37, 4, 30);
    chk("tracked length", bit_length, 8'h25);
    // Lower limit hit reloads quanta and flags
    apb(1, ADDR_CTRL1, 0);
    apb(1, ADDR_LOWER, 8'h26);
    apb(1, ADDR_MASK, 4);
    apb(0, ADDR_STATUS, 0);
    apb(1, ADDR_CTRL1, 1);
    can_node_model_inst.send(37, 4, 10);
    chk("limit irq", interrupt_out_n, 0);
    apb(1, ADDR_CTRL1, 0);
    repeat (3) @(posedge pclk);
    chk("reloaded", bit_length, 8'h28);
    apb(0, ADDR_STATUS, 0);
    chk("limit status", q & 4, 4);
    @(posedge pclk);
    chk("limit irq off", interrupt_out_n, 1);
    // Dominant pulse filtering between FDF and EOF
    for (int i = 0; i < 5; i++) begin
      apb(1, ADDR_CTRL1, {24'h0, fd_ctrl[i]});
      pulse(2);
      zeros = 0;
      can_node_model_inst.send(39, fd_low[i], 41);
      pulse(3);
      chk("pulse seen", 32'(zeros > 0), fd_exp[i]);
    end
    print_verdict;
  end
endmodule // partial_net_clock_recovery_tb

`default_nettype wire
